// ### annp_pkg.sv
package annp_pkg;
	// register indices on the management port
	localparam logic [4:0]  IDX_EXPANSION = 5'h06;
	localparam logic [4:0]  IDX_NP_TX     = 5'h07;
	localparam logic [4:0]  IDX_NP_RX     = 5'h08;

	// expansion register bit positions
	localparam int          EXP_PARTNER_AN   = 0;
	localparam int          EXP_PAGE_RCVD    = 1;
	localparam int          EXP_LOCAL_NP     = 2;
	localparam int          EXP_PARTNER_NP   = 3;
	localparam int          EXP_PD_FAULT     = 4;
	localparam int          EXP_RX_LOC       = 5;
	localparam int          EXP_RX_LOC_ABLE  = 6;

	// next-page register bit positions
	localparam int          NP_MORE   = 15;
	localparam int          NP_ACK    = 14;
	localparam int          NP_MSG    = 13;
	localparam int          NP_ACK2   = 12;
	localparam int          NP_TOGGLE = 11;
	localparam int          CODE_W    = 11;

	// reset values
	localparam logic [10:0] TX_CODE_RST = 11'h001;
	localparam logic [10:0] RX_CODE_RST = 11'h000;
	localparam logic        TX_MSG_RST  = 1'b1;

	// one link code word as seen on the page path
	typedef struct packed {
		logic        more;
		logic        ack;
		logic        msg;
		logic        ack2;
		logic        toggle;
		logic [10:0] code;
	} annp_page_t;
endpackage

// ### annp_regs.sv
`timescale 1ns/10ps
// Contract
// - expansion bit 6 always reads one
// - expansion bit 5 reads one
// - bit 4 latches parallel detection fault
// - bit 3 shows partner next-page ability
// - bit 2 fixed one, local next-page
// - bit 1 latches on new page
// - bit 0 shows partner autoneg ability
// - tx bit 15 writable, rx mirrors partner
// - tx bit 13 page type, reset one
// - tx bit 12 comply flag, reset zero
// - bit 11 toggles each page, read-only
// - tx code field writable, reset 001
// - rx bit 14 set once word received
// - rx register read-only, loaded per page
module annp_regs
(
	// clock, reset, enable
	input  wire logic               sys_clk,
	input  wire logic               arst_n,
	input  wire logic               clk_en,
	// management register port
	input  wire logic [4:0]         mgmt_addr,
	input  wire logic               mgmt_rd,
	input  wire logic               mgmt_wr,
	input  wire logic [15:0]        mgmt_wdata,
	output logic      [15:0]        mgmt_rdata,
	// negotiation engine status
	input  wire logic               partner_an_able,
	input  wire logic               partner_np_able,
	input  wire logic               pd_fault_evt,
	input  wire logic               page_rx_valid,
	input  wire annp_pkg::annp_page_t page_rx,
	input  wire logic               page_tx_taken,
	// page offered to the engine
	output annp_pkg::annp_page_t    page_tx
);

	////////////////////////////////////////////////////////////////////////////
	logic                  pd_fault;
	logic                  page_rcvd;
	logic                  np_partner;
	logic                  an_partner;
	annp_pkg::annp_page_t  tx_reg;
	annp_pkg::annp_page_t  rx_reg;
	logic [15:0]           exp_word;
	logic [15:0]           tx_word;
	logic [15:0]           rx_word;
	logic [15:0]           next_rdata;
	wire                   rd_exp = mgmt_rd && mgmt_addr == annp_pkg::IDX_EXPANSION;
	wire                   wr_tx  = mgmt_wr && mgmt_addr == annp_pkg::IDX_NP_TX;
	wire                   rd_tx  = mgmt_rd && mgmt_addr == annp_pkg::IDX_NP_TX;
	wire                   rd_rx  = mgmt_rd && mgmt_addr == annp_pkg::IDX_NP_RX;
	// indices outside the bank; only the checks below read this
	wire                   rd_none = mgmt_rd && !rd_exp && !rd_tx && !rd_rx;

	function automatic logic [15:0] page_word(input annp_pkg::annp_page_t p);
		page_word = {p.more, p.ack, p.msg, p.ack2, p.toggle, p.code};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		exp_word = 16'h0000;
		exp_word[annp_pkg::EXP_RX_LOC_ABLE] = 1'b1;
		exp_word[annp_pkg::EXP_RX_LOC]      = 1'b1;
		exp_word[annp_pkg::EXP_PD_FAULT]    = pd_fault;
		exp_word[annp_pkg::EXP_PARTNER_NP]  = np_partner;
		exp_word[annp_pkg::EXP_LOCAL_NP]    = 1'b1;
		exp_word[annp_pkg::EXP_PAGE_RCVD]   = page_rcvd;
		exp_word[annp_pkg::EXP_PARTNER_AN]  = an_partner;
	end

	// reserved bit 14 of transmit reads zero; ack belongs to the engine
	assign tx_word = page_word(tx_reg) & 16'hbfff;
	assign rx_word = page_word(rx_reg);

	assign next_rdata = (mgmt_addr == annp_pkg::IDX_EXPANSION) ? exp_word :
	                    (mgmt_addr == annp_pkg::IDX_NP_TX)     ? tx_word  :
	                    (mgmt_addr == annp_pkg::IDX_NP_RX)     ? rx_word  : 16'h0000;

	assign page_tx = tx_reg;

	////////////////////////////////////////////////////////////////////////////
	// latched-high flags: an event in the read cycle wins so it is not lost
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pd_fault   <= 1'b0;
			page_rcvd  <= 1'b0;
			np_partner <= 1'b0;
			an_partner <= 1'b0;
			mgmt_rdata <= 16'h0000;
		end
		else if (clk_en)
		begin
			pd_fault   <= pd_fault_evt | (pd_fault & ~rd_exp);
			page_rcvd  <= page_rx_valid | (page_rcvd & ~rd_exp);
			np_partner <= partner_np_able;
			an_partner <= partner_an_able;
			if (mgmt_rd)
				mgmt_rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transmit page: software fields plus a toggle flipped per sent page
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_reg        <= '0;
			tx_reg.msg    <= annp_pkg::TX_MSG_RST;
			tx_reg.code   <= annp_pkg::TX_CODE_RST;
		end
		else if (clk_en)
		begin
			if (wr_tx)
			begin
				tx_reg.more <= mgmt_wdata[annp_pkg::NP_MORE];
				tx_reg.msg  <= mgmt_wdata[annp_pkg::NP_MSG];
				tx_reg.ack2 <= mgmt_wdata[annp_pkg::NP_ACK2];
				tx_reg.code <= mgmt_wdata[annp_pkg::CODE_W-1:0];
			end
			if (page_tx_taken)
				tx_reg.toggle <= ~tx_reg.toggle;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receive page: loaded from each partner page with ack forced to one, never by software
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_reg      <= '0;
			rx_reg.code <= annp_pkg::RX_CODE_RST;
		end
		else if (clk_en && page_rx_valid)
		begin
			rx_reg     <= page_rx;
			rx_reg.ack <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	sequence s_page_in;
		clk_en && page_rx_valid;
	endsequence

	a_page_rcvd_set: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_page_in |=> page_rcvd)
		else $error("page received flag not set");
	a_pd_fault_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(pd_fault && !(clk_en && rd_exp)) |=> pd_fault)
		else $error("fault flag dropped without read");
	a_flag_read_clr: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_en && rd_exp && !page_rx_valid) |=> !page_rcvd)
		else $error("page flag not cleared by read");
	a_fixed_ones: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_en && rd_exp) |=> mgmt_rdata[annp_pkg::EXP_RX_LOC_ABLE]
		&& mgmt_rdata[15:7] == 9'h000)
		else $error("fixed expansion bits wrong");
	a_rx_ack_set: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_page_in |=> rx_reg.ack && rx_reg.code == $past(page_rx.code))
		else $error("receive page not captured");
	a_toggle_flip: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_en && page_tx_taken) |=> tx_reg.toggle != $past(tx_reg.toggle))
		else $error("toggle did not flip");
	a_tx_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_en && wr_tx) |=> tx_reg.code == $past(mgmt_wdata[10:0])
		&& tx_reg.more == $past(mgmt_wdata[15]))
		else $error("transmit write lost");
	a_tx_stable: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!(clk_en && wr_tx) |=> $stable(tx_reg.code))
		else $error("transmit code changed without write");
	a_partner_np: assert property (@(posedge sys_clk) disable iff (!arst_n)
		clk_en |=> np_partner == $past(partner_np_able))
		else $error("partner next-page bit stale");

	////////////////////////////////////////////////////////////////////////////
	// management reads: the word seen one edge after each kind of strobe
	sequence s_exp_read;
		clk_en && rd_exp;
	endsequence

	sequence s_tx_read;
		clk_en && rd_tx;
	endsequence

	sequence s_rx_read;
		clk_en && rd_rx;
	endsequence

	sequence s_none_read;
		clk_en && rd_none;
	endsequence

	sequence s_tx_write;
		clk_en && wr_tx;
	endsequence

	// checks are on the read word, not on exp_word, so a broken mux is seen
	a_rx_loc_bit: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_exp_read |=> mgmt_rdata[annp_pkg::EXP_RX_LOC])
		else $error("storage location bit not set");

	a_local_np_bit: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_exp_read |=> mgmt_rdata[annp_pkg::EXP_LOCAL_NP])
		else $error("local next-page bit not set");

	a_fault_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_exp_read |=> mgmt_rdata[annp_pkg::EXP_PD_FAULT] == $past(pd_fault))
		else $error("fault bit read wrong");

	a_np_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_exp_read |=> mgmt_rdata[annp_pkg::EXP_PARTNER_NP] == $past(np_partner))
		else $error("partner next-page bit read wrong");

	a_page_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_exp_read |=> mgmt_rdata[annp_pkg::EXP_PAGE_RCVD] == $past(page_rcvd))
		else $error("page received bit read wrong");

	a_an_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_exp_read |=> mgmt_rdata[annp_pkg::EXP_PARTNER_AN] == $past(an_partner))
		else $error("partner autoneg bit read wrong");

	a_none_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_none_read |=> mgmt_rdata == 16'h0000)
		else $error("unmapped index read not zero");

	a_rdata_stands: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!(clk_en && mgmt_rd) |=> $stable(mgmt_rdata))
		else $error("read data changed without read");

	////////////////////////////////////////////////////////////////////////////
	// latched flags and partner levels
	a_pd_fault_set: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_en && pd_fault_evt) |=> pd_fault)
		else $error("fault flag not set");

	a_pd_read_clr: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_en && rd_exp && !pd_fault_evt) |=> !pd_fault)
		else $error("fault flag not cleared by read");

	a_page_rcvd_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(page_rcvd && !(clk_en && rd_exp)) |=> page_rcvd)
		else $error("page flag dropped without read");

	a_partner_an: assert property (@(posedge sys_clk) disable iff (!arst_n)
		clk_en |=> an_partner == $past(partner_an_able))
		else $error("partner autoneg bit stale");

	////////////////////////////////////////////////////////////////////////////
	// transmit page fields
	a_tx_type_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_tx_write |=> tx_reg.msg == $past(mgmt_wdata[annp_pkg::NP_MSG]))
		else $error("page type write lost");

	a_tx_comply_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_tx_write |=> tx_reg.ack2 == $past(mgmt_wdata[annp_pkg::NP_ACK2]))
		else $error("comply bit write lost");

	a_tx_ctrl_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!(clk_en && wr_tx) |=> $stable(tx_reg.more) && $stable(tx_reg.msg)
		&& $stable(tx_reg.ack2))
		else $error("transmit control changed without write");

	a_tx_readback: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_tx_read |=> mgmt_rdata[10:0] == $past(tx_reg.code)
		&& mgmt_rdata[annp_pkg::NP_MSG] == $past(tx_reg.msg))
		else $error("transmit read wrong");

	a_tx_ack_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_tx_read |=> !mgmt_rdata[annp_pkg::NP_ACK]
		&& mgmt_rdata[annp_pkg::NP_MORE] == $past(tx_reg.more))
		else $error("transmit upper bits read wrong");

	a_toggle_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_tx_read |=> mgmt_rdata[annp_pkg::NP_TOGGLE] == $past(tx_reg.toggle))
		else $error("toggle read wrong");

	a_toggle_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!(clk_en && page_tx_taken) |=> $stable(tx_reg.toggle))
		else $error("toggle moved without sent page");

	////////////////////////////////////////////////////////////////////////////
	// receive page
	a_rx_fields: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_page_in |=> rx_reg.more == $past(page_rx.more)
		&& rx_reg.msg == $past(page_rx.msg)
		&& rx_reg.ack2 == $past(page_rx.ack2)
		&& rx_reg.toggle == $past(page_rx.toggle))
		else $error("receive page fields not captured");

	a_rx_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!(clk_en && page_rx_valid) |=> $stable(rx_reg))
		else $error("receive page changed without page");

	a_rx_ack_keep: assert property (@(posedge sys_clk) disable iff (!arst_n)
		rx_reg.ack |=> rx_reg.ack)
		else $error("receive ack dropped");

	a_rx_readback: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_rx_read |=> mgmt_rdata[10:0] == $past(rx_reg.code)
		&& mgmt_rdata[annp_pkg::NP_ACK] == $past(rx_reg.ack))
		else $error("receive read wrong");

	////////////////////////////////////////////////////////////////////////////
	// a low enable must hold the page, read-data and latched flag registers, whatever the strobes do
	a_freeze_all: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!clk_en |=> $stable(tx_reg) && $stable(rx_reg) && $stable(mgmt_rdata)
		&& $stable(pd_fault) && $stable(page_rcvd))
		else $error("state moved while enable low");

endmodule

// ### annp_partner.sv
`timescale 1ns/10ps
module annp_partner
(
	// clock
	input  wire logic                 sys_clk,
	// page path and status toward the registers
	input  wire annp_pkg::annp_page_t page_tx,
	output annp_pkg::annp_page_t      page_rx,
	output logic                      page_rx_valid,
	output logic                      page_tx_taken,
	output logic                      pd_fault_evt,
	output logic                      partner_an_able,
	output logic                      partner_np_able
);
	annp_pkg::annp_page_t sent_page = 16'h0000;
	initial
	begin
		{page_rx_valid, page_tx_taken, pd_fault_evt} = 3'h0;
		{partner_an_able, partner_np_able} = 2'h0;
		page_rx = 16'h0000;
	end
	task automatic set_ability(input logic an, input logic np);
		@(negedge sys_clk);
		partner_an_able = an;
		partner_np_able = np;
	endtask
	// released page lines show the inverse so stale data never looks valid
	task automatic send_page(input annp_pkg::annp_page_t p);
		@(negedge sys_clk);
		page_rx = p;
		page_rx_valid = 1'b1;
		@(negedge sys_clk);
		page_rx_valid = 1'b0;
		page_rx = ~p;
	endtask
	task automatic take_page();
		@(negedge sys_clk);
		page_tx_taken = 1'b1;
		sent_page = page_tx;
		@(negedge sys_clk);
		page_tx_taken = 1'b0;
	endtask
	task automatic fault_pulse();
		@(negedge sys_clk);
		pd_fault_evt = 1'b1;
		@(negedge sys_clk);
		pd_fault_evt = 1'b0;
	endtask
endmodule

// ### test_annp_regs.sv
`timescale 1ns/10ps
module test_annp_regs;
	localparam logic [4:0] IX_EXP = annp_pkg::IDX_EXPANSION;
	localparam logic [4:0] IX_TX  = annp_pkg::IDX_NP_TX;
	localparam logic [4:0] IX_RX  = annp_pkg::IDX_NP_RX;
	logic                 sys_clk = 1'b0;
	logic                 arst_n = 1'b0;
	logic                 clk_en = 1'b1;
	logic [4:0]           mgmt_addr = 5'h00;
	logic                 mgmt_rd = 1'b0;
	logic                 mgmt_wr = 1'b0;
	logic [15:0]          mgmt_wdata = 16'h0000;
	logic [15:0]          mgmt_rdata;
	logic                 an_able, np_able, pd_evt, rx_valid, tx_taken;
	annp_pkg::annp_page_t page_rx, page_tx;
	int                   err_total = 0;
	int                   n_checks = 0;
	always #25 sys_clk = ~sys_clk;
	annp_regs annp_regs_inst (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
		.mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata),
		.mgmt_rdata(mgmt_rdata), .partner_an_able(an_able), .partner_np_able(np_able),
		.pd_fault_evt(pd_evt), .page_rx_valid(rx_valid), .page_rx(page_rx),
		.page_tx_taken(tx_taken), .page_tx(page_tx));
	annp_partner annp_partner_inst (.sys_clk(sys_clk), .page_tx(page_tx), .page_rx(page_rx),
		.page_rx_valid(rx_valid), .page_tx_taken(tx_taken), .pd_fault_evt(pd_evt),
		.partner_an_able(an_able), .partner_np_able(np_able));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// read data is registered, so it is sampled a full cycle after the strobe drops
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		@(negedge sys_clk);
		mgmt_addr = a;
		mgmt_rd = 1'b1;
		@(negedge sys_clk);
		mgmt_rd = 1'b0;
		@(negedge sys_clk);
		chk(mgmt_rdata, exp);
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge sys_clk);
		mgmt_addr = a;
		mgmt_wdata = d;
		mgmt_wr = 1'b1;
		@(negedge sys_clk);
		mgmt_wr = 1'b0;
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic reset_values();
		rd(IX_EXP, 16'h0064);
		rd(IX_TX, 16'h2001);
		rd(IX_RX, 16'h0000);
		chk(page_tx, 16'h2001);
	endtask
	task automatic expansion_flags();
		annp_partner_inst.set_ability(1'b1, 1'b1);
		rd(IX_EXP, 16'h006d);
		annp_partner_inst.fault_pulse();
		rd(IX_EXP, 16'h007d);
		rd(IX_EXP, 16'h006d);
		annp_partner_inst.set_ability(1'b0, 1'b0);
		rd(IX_EXP, 16'h0064);
		// event and clearing read on one edge: old word read, flag kept
		fork
			rd(IX_EXP, 16'h0064);
			annp_partner_inst.fault_pulse();
		join
		rd(IX_EXP, 16'h0074);
		rd(IX_EXP, 16'h0064);
	endtask
	// read-only places must ignore writes; an unmapped index must read zero
	task automatic tx_write();
		wr(IX_TX, 16'h9fff);
		wr(IX_EXP, 16'hffff);
		wr(IX_RX, 16'hffff);
		rd(IX_TX, 16'h97ff);
		rd(IX_EXP, 16'h0064);
		rd(IX_RX, 16'h0000);
		rd(5'h1f, 16'h0000);
		wr(IX_TX, 16'h0000);
		rd(IX_TX, 16'h0000);
	endtask
	task automatic tx_toggle();
		wr(IX_TX, 16'h3123);
		annp_partner_inst.take_page();
		chk(annp_partner_inst.sent_page, 16'h3123);
		rd(IX_TX, 16'h3923);
		annp_partner_inst.take_page();
		chk(annp_partner_inst.sent_page, 16'h3923);
		rd(IX_TX, 16'h3123);
	endtask
	// a low enable must swallow every event, write and page hand-off
	task automatic clk_freeze();
		@(negedge sys_clk);
		clk_en = 1'b0;
		annp_partner_inst.fault_pulse();
		annp_partner_inst.send_page(16'h4321);
		wr(IX_TX, 16'h8000);
		annp_partner_inst.take_page();
		@(negedge sys_clk);
		clk_en = 1'b1;
		rd(IX_EXP, 16'h0064);
		rd(IX_TX, 16'h3123);
		rd(IX_RX, 16'h0000);
	endtask
	task automatic rx_page();
		fork
			annp_partner_inst.send_page(16'h9a55);
			rd(IX_EXP, 16'h0064);
		join
		rd(IX_EXP, 16'h0066);
		rd(IX_EXP, 16'h0064);
		rd(IX_RX, 16'hda55);
	endtask
	// a second reset in mid-run must bring back every default
	task automatic mid_reset();
		@(negedge sys_clk);
		arst_n = 1'b0;
		repeat (2) @(negedge sys_clk);
		arst_n = 1'b1;
		chk(page_tx, 16'h2001);
		rd(IX_TX, 16'h2001);
		rd(IX_RX, 16'h0000);
		rd(IX_EXP, 16'h0064);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(negedge sys_clk);
		arst_n = 1'b1;
		reset_values();
		expansion_flags();
		tx_write();
		tx_toggle();
		clk_freeze();
		rx_page();
		mid_reset();
		complete_run();
	end
	// about 120 cycles are needed; a hang is cut well beyond that
	initial
	begin
		repeat (1000) @(posedge sys_clk);
		err_total++;
		complete_run();
	end
endmodule
